// >>> rtl/tci_capture_top.sv
// three-channel input capture unit with shared time base and wishbone slave
`timescale 1ns/10ps
module tci_capture_top
(
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [tci_pkg::TCI_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [tci_pkg::TCI_DAT_W-1:0] wb_dat_i,
  output logic      [tci_pkg::TCI_DAT_W-1:0] wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          captureInput1,
  input  wire logic                          captureInput2,
  input  wire logic                          captureInput3,
  input  wire logic [2:0]                    qdecLoad,
  input  wire logic [tci_pkg::TCI_TB_W-1:0]  qdecData,
  output logic                               channel1EventFlag,
  output logic                               channel2EventFlag,
  output logic                               channel3EventFlag,
  output logic                               specialEventTrig,
  output logic                               quadratureDecoderActive,
  output logic      [tci_pkg::TCI_TB_W-1:0]  sharedTimebase
);
  import tci_pkg::*;

  tci_phase_e                     phaseReg;
  logic                           q1Stb;
  logic                           q2Stb;
  logic                           q4Stb;
  logic [TCI_CFG_MODE_W-1:0]      modeReg [TCI_NCH];
  logic [TCI_NCH-1:0]             resetEnReg;
  logic [TCI_TBC_W-1:0]           timebaseControlReg;
  logic [TCI_TB_W-1:0]            tbReg;
  logic [TCI_NCH-1:0]             flagReg;
  logic [TCI_TB_W-1:0]            bufReg [TCI_NCH];
  logic                           qdecReg;
  logic                           ackReg;
  logic [TCI_DAT_W-1:0]           rdataReg;
  logic [TCI_DAT_W-1:0]           rdataNext;
  logic                           wrStb;
  logic [TCI_NCH-1:0]             pinVec;
  logic [TCI_NCH-1:0]             capVec;
  logic [TCI_NCH-1:0]             rstVec;
  logic [TCI_NCH-1:0]             trigVec;
  logic                           trigFire;
  logic                           trigResets;
  logic                           wrTb;
  logic                           wrTbc;
  logic [TCI_DAT_W-1:0]           chCfgWord;
  logic [TCI_DAT_W-1:0]           tbMerge;
  logic [TCI_DAT_W-1:0]           bufMerge [TCI_NCH];

  // byte-lane merge for wishbone writes
  function automatic logic [TCI_DAT_W-1:0] laneMerge
  (
    input logic [TCI_DAT_W-1:0] oldVal,
    input logic [TCI_DAT_W-1:0] newVal,
    input logic [3:0]           sel
  );
    logic [TCI_DAT_W-1:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        res[b*8 +: 8] = newVal[b*8 +: 8];
    return res;
  endfunction

  // ----------------------------------------------------------------
  // quarter-phase sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      phaseReg <= TCI_Q1;
    else
      phaseReg <= tci_phase_e'(phaseReg + 2'b01);
  end

  // strobes mark the edge that starts the phase they are named after
  assign q1Stb = (phaseReg == TCI_Q4);
  assign q2Stb = (phaseReg == TCI_Q1);
  assign q4Stb = (phaseReg == TCI_Q3);

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  assign pinVec = {captureInput3, captureInput2, captureInput1};

  for (genvar g = 0; g < TCI_NCH; g++)
  begin : gCh
    tci_chan_if chIf ();
    assign chIf.mode      = modeReg[g];
    assign chIf.resetEn   = resetEnReg[g];
    assign chIf.enable    = ~qdecReg;
    assign chIf.sampleStb = q2Stb;
    assign chIf.propStb   = q4Stb;
    assign chIf.pin       = pinVec[g];
    assign capVec[g]      = chIf.capture;
    assign rstVec[g]      = chIf.tbReset;
    assign trigVec[g]     = chIf.trigger;
    tci_channel #(.HAS_TRIG(g == 0)) uChan
    (
      .core_clk (core_clk),
      .nrst     (nrst),
      .ch       (chIf)
    );
  end

  // only channel 1 is built with trigger decode
  assign trigFire   = q1Stb & trigVec[0];
  assign trigResets = trigFire & ~timebaseControlReg[TCI_TBC_RESN];

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      ackReg <= 1'b0;
    else
      ackReg <= wb_cyc_i & wb_stb_i & ~ackReg;
  end

  assign wb_ack_o = ackReg;
  // writes land on the edge where the master sees ack
  assign wrStb = wb_cyc_i & wb_stb_i & wb_we_i & ackReg;
  assign wrTb  = wrStb && (wb_adr_i == TCI_OFS_TB);
  assign wrTbc = wrStb && (wb_adr_i == TCI_OFS_TBCTRL);

  always_comb
  begin
    chCfgWord = '0;
    for (int i = 0; i < TCI_NCH; i++)
    begin
      chCfgWord[i*TCI_CFG_STRIDE +: TCI_CFG_MODE_W] = modeReg[i];
      chCfgWord[i*TCI_CFG_STRIDE + TCI_CFG_REN_BIT] = resetEnReg[i];
    end
  end

  // unmapped addresses are acked and read as zero
  always_comb
  begin
    rdataNext = '0;
    unique case (wb_adr_i)
      TCI_OFS_CHCFG:  rdataNext = chCfgWord;
      TCI_OFS_TBCTRL: rdataNext[TCI_TBC_W-1:0] = timebaseControlReg;
      TCI_OFS_TB:     rdataNext[TCI_TB_W-1:0] = tbReg;
      TCI_OFS_FLAGS:  rdataNext[TCI_NCH-1:0] = flagReg;
      TCI_OFS_BUF1:   rdataNext[TCI_TB_W-1:0] = bufReg[0];
      TCI_OFS_BUF2:   rdataNext[TCI_TB_W-1:0] = bufReg[1];
      TCI_OFS_BUF3:   rdataNext[TCI_TB_W-1:0] = bufReg[2];
      TCI_OFS_QDEC:   rdataNext[TCI_QDEC_EN] = qdecReg;
      default:        rdataNext = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rdataReg <= '0;
    else if (wb_cyc_i && wb_stb_i && !ackReg)
      rdataReg <= rdataNext;
  end

  assign wb_dat_o = rdataReg;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < TCI_NCH; i++)
        modeReg[i] <= TCI_MODE_RST;
      resetEnReg <= '0;
      qdecReg    <= 1'b0;
    end
    else if (wrStb)
    begin
      if (wb_adr_i == TCI_OFS_CHCFG)
        for (int i = 0; i < TCI_NCH; i++)
          if (wb_sel_i[i])
          begin
            modeReg[i]    <= wb_dat_i[i*TCI_CFG_STRIDE +: TCI_CFG_MODE_W];
            resetEnReg[i] <= wb_dat_i[i*TCI_CFG_STRIDE + TCI_CFG_REN_BIT];
          end
      if (wb_adr_i == TCI_OFS_QDEC && wb_sel_i[0])
        qdecReg <= wb_dat_i[TCI_QDEC_EN];
    end
  end

  assign quadratureDecoderActive = qdecReg;

  // ----------------------------------------------------------------
  // time base control and counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      timebaseControlReg <= TCI_TBC_RST;
    else if (wrTbc && wb_sel_i[0])
      timebaseControlReg <= wb_dat_i[TCI_TBC_W-1:0];
    else if (trigResets && timebaseControlReg[TCI_TBC_TSM]
             && !timebaseControlReg[TCI_TBC_RUN])
      timebaseControlReg[TCI_TBC_RUN] <= 1'b1;
  end

  // a call result cannot be sliced, so the merged words are held here
  always_comb
  begin
    tbMerge = laneMerge(TCI_DAT_W'(tbReg), wb_dat_i, wb_sel_i);
    for (int i = 0; i < TCI_NCH; i++)
      bufMerge[i] = laneMerge(TCI_DAT_W'(bufReg[i]), wb_dat_i, wb_sel_i);
  end

  // mode changes never touch the count; the counter only sees events
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      tbReg <= TCI_TB_RST;
    else if (wrTb)
      tbReg <= tbMerge[TCI_TB_W-1:0];
    else if (q1Stb && ((|rstVec) || trigResets))
      tbReg <= TCI_TB_RST;
    else if (q1Stb && timebaseControlReg[TCI_TBC_RUN])
      tbReg <= tbReg + 16'h0001;
  end

  assign sharedTimebase = tbReg;

  // ----------------------------------------------------------------
  // capture buffers (remapped to the decoder while it is active)
  // ----------------------------------------------------------------
  // buffers take the count from before this Q1 reset
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < TCI_NCH; i++)
        bufReg[i] <= TCI_TB_RST;
    end
    else
    begin
      for (int i = 0; i < TCI_NCH; i++)
      begin
        if (qdecReg)
        begin
          if (wrStb && wb_adr_i == TCI_OFS_BUF1 + 8'(4 * i))
            bufReg[i] <= bufMerge[i][TCI_TB_W-1:0];
          else if (qdecLoad[i])
            bufReg[i] <= qdecData;
        end
        else if (q1Stb && capVec[i])
          bufReg[i] <= tbReg;
      end
    end
  end

  // ----------------------------------------------------------------
  // event flags: write one to clear, a new event wins
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      flagReg <= '0;
    else
    begin
      for (int i = 0; i < TCI_NCH; i++)
      begin
        if (q1Stb && capVec[i])
          flagReg[i] <= 1'b1;
        else if (wrStb && wb_adr_i == TCI_OFS_FLAGS && wb_sel_i[0] && wb_dat_i[i])
          flagReg[i] <= 1'b0;
      end
    end
  end

  assign channel1EventFlag = flagReg[0];
  assign channel2EventFlag = flagReg[1];
  assign channel3EventFlag = flagReg[2];

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      specialEventTrig <= 1'b0;
    else
      specialEventTrig <= trigFire;
  end

endmodule

// >>> rtl/tci_chan_if.sv
// link between the capture top and one capture channel
`timescale 1ns/10ps
interface tci_chan_if;
  logic [3:0] mode;
  logic       resetEn;
  logic       enable;
  logic       sampleStb;
  logic       propStb;
  logic       pin;
  logic       capture;
  logic       tbReset;
  logic       trigger;

  modport ctl
  (
    output mode, resetEn, enable, sampleStb, propStb, pin,
    input  capture, tbReset, trigger
  );
  modport chan
  (
    input  mode, resetEn, enable, sampleStb, propStb, pin,
    output capture, tbReset, trigger
  );
endinterface

// >>> rtl/tci_channel.sv
// one capture channel: pin synchroniser, edge decode, prescaler, phase staging
`timescale 1ns/10ps
module tci_channel
#(
  parameter bit HAS_TRIG = 1'b0
)
(
  input  wire logic core_clk,
  input  wire logic nrst,
  tci_chan_if.chan  ch
);
  import tci_pkg::*;

  logic       pinMeta;
  logic       pinSync;
  logic       lvlReg;
  logic [3:0] preCnt;
  tci_mode_e  modePrev;
  logic       armed;
  logic       detCap;
  logic       detRst;
  logic       detTrig;
  logic       propCap;
  logic       propRst;
  logic       propTrig;
  tci_mode_e  mode;
  logic       rise;
  logic       fall;
  logic       cap;
  logic       init;
  logic       trig;
  logic       preInc;
  logic       isPw;
  logic       rst;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
    end
    else
    begin
      pinMeta <= ch.pin;
      pinSync <= pinMeta;
    end
  end

  // ----------------------------------------------------------------
  // edge decode
  // ----------------------------------------------------------------
  // quadrature decoder owns the pins while enabled
  assign mode = ch.enable ? tci_mode_e'(ch.mode) : TCI_M_OFF;
  assign rise = pinSync & ~lvlReg;
  assign fall = ~pinSync & lvlReg;
  assign isPw = (mode == TCI_M_PW_FR) || (mode == TCI_M_PW_RF);

  always_comb
  begin
    cap    = 1'b0;
    init   = 1'b0;
    trig   = 1'b0;
    preInc = 1'b0;
    unique case (mode)
      TCI_M_OFF:       cap = 1'b0;
      TCI_M_FALL:      cap = fall;
      TCI_M_RISE:      cap = rise;
      TCI_M_RISE4:
      begin
        preInc = rise;
        cap    = rise & (preCnt >= TCI_PRE4);
      end
      TCI_M_RISE16:
      begin
        preInc = rise;
        cap    = rise & (preCnt >= TCI_PRE16);
      end
      TCI_M_PERIOD:    cap = rise;
      TCI_M_PW_FR:
      begin
        init = fall;
        cap  = rise | (fall & armed);
      end
      TCI_M_PW_RF:
      begin
        init = rise;
        cap  = fall | (rise & armed);
      end
      TCI_M_STATE:     cap = rise | fall;
      TCI_M_TRIG_FALL: trig = HAS_TRIG & fall;
      TCI_M_TRIG_RISE: trig = HAS_TRIG & rise;
      default:         cap = 1'b0;
    endcase
  end

  // pulse-width always resets on the initiating edge; others only if enabled
  assign rst = isPw ? init : (cap & ch.resetEn);

  // ----------------------------------------------------------------
  // prescaler and first-edge tracking
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      preCnt <= 4'h0;
    else if (mode == TCI_M_OFF)
      preCnt <= 4'h0;
    else if (ch.sampleStb && preInc)
      preCnt <= cap ? 4'h0 : preCnt + 4'h1;
  end

  // a direct mode change keeps the count, so the first capture may come early
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      modePrev <= TCI_M_OFF;
      armed    <= 1'b0;
    end
    else
    begin
      modePrev <= mode;
      if (mode != modePrev)
        armed <= 1'b1;
      else if (ch.sampleStb && (rise || fall))
        armed <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sample on Q2, propagate on Q4
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lvlReg  <= 1'b0;
      detCap  <= 1'b0;
      detRst  <= 1'b0;
      detTrig <= 1'b0;
    end
    else if (ch.sampleStb)
    begin
      lvlReg  <= pinSync;
      detCap  <= cap;
      detRst  <= rst;
      detTrig <= trig;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      propCap  <= 1'b0;
      propRst  <= 1'b0;
      propTrig <= 1'b0;
    end
    else if (ch.propStb)
    begin
      propCap  <= detCap;
      propRst  <= detRst;
      propTrig <= detTrig;
    end
  end

  assign ch.capture = propCap;
  assign ch.tbReset = propRst;
  assign ch.trigger = propTrig;

endmodule

// >>> rtl/tci_pkg.sv
// constants, field layout and mode codes of the three-channel input capture unit
package tci_pkg;

  localparam int TCI_NCH  = 3;
  localparam int TCI_TB_W = 16;
  localparam int TCI_ADR_W = 8;
  localparam int TCI_DAT_W = 32;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] TCI_OFS_CHCFG  = 8'h00;
  localparam logic [7:0] TCI_OFS_TBCTRL = 8'h04;
  localparam logic [7:0] TCI_OFS_TB     = 8'h08;
  localparam logic [7:0] TCI_OFS_FLAGS  = 8'h0c;
  localparam logic [7:0] TCI_OFS_BUF1   = 8'h10;
  localparam logic [7:0] TCI_OFS_BUF2   = 8'h14;
  localparam logic [7:0] TCI_OFS_BUF3   = 8'h18;
  localparam logic [7:0] TCI_OFS_QDEC   = 8'h1c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TCI_CFG_STRIDE  = 8;
  localparam int TCI_CFG_MODE_W  = 4;
  localparam int TCI_CFG_REN_BIT = 6;
  localparam int TCI_TBC_RUN     = 0;
  localparam int TCI_TBC_TSM     = 1;
  localparam int TCI_TBC_RESN    = 2;
  localparam int TCI_TBC_W       = 3;
  localparam int TCI_QDEC_EN     = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [TCI_TBC_W-1:0] TCI_TBC_RST  = 3'h0;
  localparam logic [TCI_TB_W-1:0]  TCI_TB_RST   = 16'h0000;
  localparam logic [3:0]           TCI_MODE_RST = 4'h0;

  // prescaler terminal counts for every 4th / 16th rising edge
  localparam logic [3:0] TCI_PRE4  = 4'h3;
  localparam logic [3:0] TCI_PRE16 = 4'hf;

  typedef enum logic [3:0] {
    TCI_M_OFF       = 4'b0000,
    TCI_M_FALL      = 4'b0001,
    TCI_M_RISE      = 4'b0010,
    TCI_M_RISE4     = 4'b0011,
    TCI_M_RISE16    = 4'b0100,
    TCI_M_PERIOD    = 4'b0101,
    TCI_M_PW_FR     = 4'b0110,
    TCI_M_PW_RF     = 4'b0111,
    TCI_M_STATE     = 4'b1000,
    TCI_M_TRIG_FALL = 4'b1110,
    TCI_M_TRIG_RISE = 4'b1111
  } tci_mode_e;

  // instruction-cycle quarter phases
  typedef enum logic [1:0] {
    TCI_Q1 = 2'b00,
    TCI_Q2 = 2'b01,
    TCI_Q3 = 2'b10,
    TCI_Q4 = 2'b11
  } tci_phase_e;

endpackage

// >>> tb/tci_capture_properties.sv
// concurrent checks on the capture unit's top-level ports
`timescale 1ns/10ps
module tci_capture_properties
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        channel1EventFlag,
  input wire logic        channel2EventFlag,
  input wire logic        channel3EventFlag,
  input wire logic        specialEventTrig,
  input wire logic        quadratureDecoderActive,
  input wire logic [15:0] sharedTimebase
);
  import tci_pkg::*;
  logic wrAck;
  logic resnReg;

  assign wrAck = wb_ack_o && wb_we_i;

  // shadow of the trigger reset gate, the only control these checks need
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      resnReg <= 1'b0;
    else if (wrAck && wb_adr_i == TCI_OFS_TBCTRL && wb_sel_i[0])
      resnReg <= wb_dat_i[TCI_TBC_RESN];
  end

  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_ack_answer: assert property (s_req |=> s_ackPulse)
    else $error("ack not a single pulse after request");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_tb_steps: assert property (!$past(wrAck && wb_adr_i == TCI_OFS_TB) |->
    sharedTimebase == $past(sharedTimebase) || sharedTimebase == 16'h0000 ||
    sharedTimebase == $past(sharedTimebase) + 16'h0001)
    else $error("time base jumped");
  chk_flag_sticky: assert property ($fell(channel1EventFlag) || $fell(channel2EventFlag) ||
    $fell(channel3EventFlag) |-> $past(wrAck && wb_adr_i == TCI_OFS_FLAGS))
    else $error("event flag cleared without write");
  chk_qdec_write: assert property ($changed(quadratureDecoderActive) |->
    $past(wrAck && wb_adr_i == TCI_OFS_QDEC))
    else $error("decoder state changed without write");
  chk_trig_quiet: assert property (specialEventTrig |=> !specialEventTrig [*3])
    else $error("trigger pulse too long or too dense");
  chk_trig_noflag: assert property (specialEventTrig |->
    !($past(channel1EventFlag) && !$past(channel1EventFlag, 2)))
    else $error("channel 1 flag set by trigger");
  chk_trig_reset: assert property (specialEventTrig && !resnReg |->
    sharedTimebase == 16'h0000)
    else $error("trigger did not clear time base");
endmodule

bind tci_capture_top tci_capture_properties i_props
(
  .core_clk,
  .nrst,
  .wb_cyc_i,
  .wb_stb_i,
  .wb_we_i,
  .wb_adr_i,
  .wb_sel_i,
  .wb_dat_i,
  .wb_ack_o,
  .channel1EventFlag,
  .channel2EventFlag,
  .channel3EventFlag,
  .specialEventTrig,
  .quadratureDecoderActive,
  .sharedTimebase
);

// >>> tb/tci_hall_model.sv
// behavioural trio of hall sensors with a settable settling lag
`timescale 1ns/10ps
module tci_hall_model
(
  input wire logic       core_clk,
  input wire logic [2:0] target,
  input wire logic [3:0] lag,
  output logic     [2:0] hall
);
  logic [3:0] waitCnt = 4'h0;
  logic [2:0] hallReg = 3'h0;

  // outputs lag the commanded state so prompt and slow sensors both occur
  always @(posedge core_clk)
  begin
    if (hallReg == target)
      waitCnt <= 4'h0;
    else if (waitCnt >= lag)
      hallReg <= target;
    else
      waitCnt <= waitCnt + 4'h1;
  end

  assign hall = hallReg;
endmodule

// >>> tb/three_channel_input_capture_test.sv
// self-checking bench for the three-channel input capture unit
`timescale 1ns/10ps
module three_channel_input_capture_test;
  import tci_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [2:0]  target = 3'h0;
  logic [3:0]  lag = 4'h0;
  logic [2:0]  hall;
  logic [2:0]  qdecLoad = 3'h0;
  logic [15:0] qdecData = 16'h0;
  logic [2:0]  flag;
  logic        specialEventTrig;
  logic        quadratureDecoderActive;
  logic [15:0] sharedTimebase;
  logic [31:0] expQ[$];
  logic [3:0]  md[6] = '{TCI_M_FALL, TCI_M_RISE, TCI_M_PERIOD, TCI_M_STATE, TCI_M_TRIG_RISE, 4'h9};
  logic [7:0]  ofs[8] = '{TCI_OFS_CHCFG, TCI_OFS_TBCTRL, TCI_OFS_TB, TCI_OFS_FLAGS,
                          TCI_OFS_BUF1, TCI_OFS_BUF3, TCI_OFS_QDEC, 8'h24};
  logic [31:0] bufExp;
  logic [15:0] v;
  logic [15:0] v2;
  int          failures = 0;
  int          cmp_count = 0;
  int          trigSeen = 0;

  always #2 core_clk = ~core_clk;

  tci_hall_model i_hall
  (
    .core_clk,
    .target,
    .lag,
    .hall
  );

  tci_capture_top i_dut
  (
    .core_clk,
    .nrst,
    .wb_cyc_i,
    .wb_stb_i,
    .wb_we_i,
    .wb_adr_i,
    .wb_sel_i,
    .wb_dat_i,
    .wb_dat_o,
    .wb_ack_o,
    .captureInput1           (hall[0]),
    .captureInput2           (hall[1]),
    .captureInput3           (hall[2]),
    .qdecLoad,
    .qdecData,
    .channel1EventFlag       (flag[0]),
    .channel2EventFlag       (flag[1]),
    .channel3EventFlag       (flag[2]),
    .specialEventTrig,
    .quadratureDecoderActive,
    .sharedTimebase
  );

  task automatic compare(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      failures++;
      conclude();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // sync, phase staging and action take well under 24 cycles
  task automatic pins(input logic [2:0] t);
    @(posedge core_clk);
    target <= t;
    lag <= 4'($urandom_range(3));
    repeat (24) @(posedge core_clk);
  endtask

  always @(posedge core_clk)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      compare("read data", expQ.pop_front(), wb_dat_o);
    if (specialEventTrig === 1'b1)
      trigSeen++;
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(22250));
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    bufExp = 32'h0;
    for (int i = 0; i < 6; i++)
    begin
      wr(TCI_OFS_CHCFG, 32'h0);
      wr(TCI_OFS_FLAGS, 32'h7);
      wr(TCI_OFS_CHCFG, {28'h0, md[i]});
      v = 16'($urandom);
      wr(TCI_OFS_TB, {16'h0, v});
      pins(3'b001);
      if (i inside {1, 2, 3}) bufExp = {16'h0, v};
      v2 = 16'($urandom);
      wr(TCI_OFS_TB, {16'h0, v2});
      pins(3'b000);
      if (i inside {0, 3}) bufExp = {16'h0, v2};
      rd(TCI_OFS_BUF1, bufExp);
      rd(TCI_OFS_FLAGS, {31'h0, i < 4});
      rd(TCI_OFS_TB, {16'h0, v2});
    end
    wr(TCI_OFS_CHCFG, 32'h42);
    wr(TCI_OFS_TB, {16'h0, v});
    pins(3'b001);
    rd(TCI_OFS_BUF1, {16'h0, v});
    rd(TCI_OFS_TB, 32'h0);
    compare("time base pins", 32'h0, {16'h0, sharedTimebase});
    wr(TCI_OFS_CHCFG, 32'h0);
    pins(3'b000);
    for (int m = 4; m <= 16; m += 12)
    begin
      wr(TCI_OFS_CHCFG, 32'h0);
      wr(TCI_OFS_CHCFG, (m == 4) ? 32'(TCI_M_RISE4) : 32'(TCI_M_RISE16));
      for (int k = 1; k <= m; k++)
      begin
        wr(TCI_OFS_TB, k);
        pins(3'b001);
        pins(3'b000);
      end
      rd(TCI_OFS_BUF1, m);
    end
    wr(TCI_OFS_CHCFG, {16'h0, 4'h0, TCI_M_PW_RF, 8'h0});
    wr(TCI_OFS_TB, {16'h0, v});
    pins(3'b010);
    rd(TCI_OFS_TB, 32'h0);
    wr(TCI_OFS_TB, {16'h0, v2});
    pins(3'b000);
    rd(TCI_OFS_BUF2, {16'h0, v2});
    wr(TCI_OFS_CHCFG, 32'h080808);
    wr(TCI_OFS_FLAGS, 32'h7);
    wr(TCI_OFS_TB, {16'h0, v});
    pins(3'b100);
    rd(TCI_OFS_FLAGS, 32'h4);
    rd(TCI_OFS_BUF3, {16'h0, v});
    wr(TCI_OFS_TB, {16'h0, v2});
    pins(3'b110);
    rd(TCI_OFS_FLAGS, 32'h6);
    compare("flag pins", 32'h6, {29'h0, flag});
    rd(TCI_OFS_BUF2, {16'h0, v2});
    wr(TCI_OFS_CHCFG, 32'h0);
    pins(3'b000);
    wr(TCI_OFS_CHCFG, {28'h0, TCI_M_PW_FR});
    wr(TCI_OFS_TB, {16'h0, v});
    pins(3'b001);
    rd(TCI_OFS_BUF1, {16'h0, v});
    pins(3'b000);
    rd(TCI_OFS_TB, 32'h0);
    rd(TCI_OFS_BUF1, {16'h0, v});
    wr(TCI_OFS_FLAGS, 32'h7);
    wr(TCI_OFS_TBCTRL, 32'h2);
    wr(TCI_OFS_CHCFG, {28'h0, TCI_M_TRIG_RISE});
    pins(3'b001);
    rd(TCI_OFS_TBCTRL, 32'h3);
    wr(TCI_OFS_CHCFG, 32'h0);
    wr(TCI_OFS_CHCFG, {28'h0, TCI_M_TRIG_FALL});
    pins(3'b000);
    rd(TCI_OFS_FLAGS, 32'h0);
    wr(TCI_OFS_TBCTRL, 32'h4);
    wr(TCI_OFS_TB, {16'h0, v});
    pins(3'b001);
    pins(3'b000);
    rd(TCI_OFS_TB, {16'h0, v});
    compare("trigger count", 32'h4, 32'(trigSeen));
    wr(TCI_OFS_CHCFG, 32'h08);
    wr(TCI_OFS_FLAGS, 32'h7);
    wr(TCI_OFS_QDEC, 32'h1);
    pins(3'b001);
    rd(TCI_OFS_FLAGS, 32'h0);
    for (int c = 0; c < 3; c++)
    begin
      v = 16'($urandom);
      @(posedge core_clk);
      qdecData <= v;
      qdecLoad <= 3'b001 << c;
      @(posedge core_clk);
      qdecLoad <= 3'h0;
      rd(TCI_OFS_BUF1 + 8'(4 * c), {16'h0, v});
    end
    rd(TCI_OFS_QDEC, 32'h1);
    compare("decoder active", 32'h1, {31'h0, quadratureDecoderActive});
    conclude();
  end

  // the whole sequence needs a few thousand cycles; this allows ten times that
  initial
  begin
    #100000;
    failures++;
    conclude();
  end
endmodule
